// *** rtl/nfc_host.sv ***
// What this block does
// - Commands go out with command latch high, latched at write strobe rise.
// - Address bytes go out with address latch high, latched at write strobe rise.
// - Full address is four cycles: col low, col high nibble, row low, row high.
// - Bus decode: command, address, or data input with write protect high.
// - While read busy with select low, both strobes held high.
// - Page read 00-addr-30; copy read 00-addr-35.
// - Output column change 05-column-E0.
// - Program 80-addr-data-10; 85 column change or copy-back, confirmed 10.
// - Erase 60, two row cycles, D0.
// - ID read 90 and ECC status 7A take no confirm code.
module nfc_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // User request
  input wire nfc_pkg::nfc_cmd_type cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic protect_i,
  // Program data in
  input wire logic [7:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  // Read data and completion
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic fail_o,
  output logic [7:0] status_o,
  output logic busy_o,
  // Flash pins
  output nfc_pkg::nfc_pins_type pins_o,
  input wire logic [7:0] io_bus_i,
  input wire logic ready_busy_n_i
);
  import nfc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_WWAIT, S_WDATA, S_CMD2, S_WB, S_RDY, S_STCMD, S_RDATA, S_DONE
  } nfc_state_type;

  nfc_state_type state, next_state;
  logic ph, next_ph;
  logic [11:0] idx, next_idx;
  nfc_cmd_type cmd, next_cmd;
  logic [7:0] wbyte, next_wbyte;
  logic [7:0] rd_data, next_rd_data;
  logic rd_valid, next_rd_valid;
  logic fail, next_fail;
  logic [7:0] status, next_status;
  logic [7:0] wcnt, next_wcnt;
  logic st_rd, next_st_rd;
  logic [7:0] div;
  logic [8:0] sync_q;
  logic done;
  logic pop;
  logic tick;
  logic byte_cyc;
  logic wr_cyc;
  logic rb_ready;
  logic [7:0] io_sync;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic [2:0] asel;
  logic [7:0] abyte;
  logic [7:0] io_next;
  logic [11:0] rd_last;
  logic bad_req;
  nfc_desc_type d;
  nfc_desc_type din;
  nfc_state_type after_c1, after_addr, after_w, after_c2, after_rdy;
  nfc_pins_type pins_next;

  // Pin inputs cross into the clock domain before use
  // Ready reads as busy for two cycles after reset; that only delays the first request
  nfc_sync #(.W(9)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({ready_busy_n_i, io_bus_i}),
    .sync_o(sync_q)
  );
  assign rb_ready = sync_q[8];
  assign io_sync = sync_q[7:0];

  // Program data buffer; drain stalls while the strobe cycle is not ready
  nfc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_data_i(wr_data_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop)
  );

  // Operation shape of the held and the offered request
  assign d = nfc_desc(cmd.op);
  assign din = nfc_desc(cmd_i.op);
  assign bad_req = (din.prot && protect_i) || (din.abase == 3'd0 && din.an != 3'd0 && cmd_i.col >= PAGE_BYTES);
  assign cmd_ready_o = (state == S_IDLE) && (rb_ready || din.busy_ok);

  // Phase divider runs only across strobe cycles
  assign byte_cyc = (state == S_CMD1) || (state == S_ADDR) || (state == S_WDATA) || (state == S_CMD2)
    || (state == S_STCMD) || (state == S_RDATA);
  assign wr_cyc = byte_cyc && (state != S_RDATA);
  assign tick = byte_cyc && (div == 8'(PH_CYC - 1));

  // Address byte order: col low, col high nibble, row low, row high
  assign asel = d.abase + idx[2:0];
  assign abyte = (asel == 3'd0) ? cmd.col[7:0] :
    (asel == 3'd1) ? {4'h0, cmd.col[11:8]} :
    (asel == 3'd2) ? cmd.row[7:0] :
    (asel == 3'd3) ? cmd.row[15:8] : 8'h00;
  assign io_next = (state == S_CMD1) ? d.c1 :
    (state == S_CMD2) ? d.c2 :
    (state == S_STCMD) ? C_STATUS :
    (state == S_ADDR) ? abyte : wbyte;

  // Next stage after each part of an operation
  assign after_w = d.has_c2 ? S_CMD2 : S_WB;
  assign after_addr = d.wr ? ((cmd.len != 12'd0) ? S_WWAIT : after_w) : after_w;
  assign after_c1 = (d.an != 3'd0) ? S_ADDR : (d.rd ? S_RDATA : (d.busy ? S_WB : S_DONE));
  assign after_c2 = S_WB;
  assign after_rdy = d.stat ? S_STCMD : ((d.rd && cmd.len != 12'd0) ? S_RDATA : S_DONE);
  assign rd_last = st_rd ? 12'd1 : cmd.len;

  // Sequencer
  always_comb begin
    next_state = state;
    next_ph = ph;
    next_idx = idx;
    next_cmd = cmd;
    next_wbyte = wbyte;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_fail = fail;
    next_status = status;
    next_wcnt = wcnt;
    next_st_rd = st_rd;
    pop = 1'b0;
    case (state)
      S_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          next_cmd = cmd_i;
          next_fail = 1'b0;
          next_st_rd = 1'b0;
          next_idx = 12'd0;
          next_ph = 1'b0;
          next_state = bad_req ? S_DONE : S_CMD1;
          if (bad_req) next_fail = 1'b1;
        end
      end
      S_WWAIT: begin
        // Empty buffer holds the strobe high rather than send stale data
        if (fifo_valid) begin
          pop = 1'b1;
          next_wbyte = fifo_data;
          next_state = S_WDATA;
        end
      end
      S_WB: begin
        next_wcnt = wcnt + 8'd1;
        if (wcnt == 8'(WB_CYC - 1)) begin
          next_wcnt = 8'd0;
          next_state = S_RDY;
        end
      end
      S_RDY: begin
        if (rb_ready) next_state = after_rdy;
      end
      S_DONE: next_state = S_IDLE;
      default: begin
        if (tick && !ph) begin
          next_ph = 1'b1;
          if (state == S_RDATA) begin
            // Sample late in the low phase, after the sync delay
            if (st_rd) begin
              next_status = io_sync;
              next_fail = io_sync[ST_FAIL_BIT];
            end else begin
              next_rd_data = io_sync;
              next_rd_valid = 1'b1;
            end
          end
        end else if (tick) begin
          next_ph = 1'b0;
          next_idx = 12'd0;
          case (state)
            S_CMD1: next_state = after_c1;
            S_ADDR: begin
              next_idx = idx + 12'd1;
              if (idx[2:0] == d.an - 3'd1) begin
                next_idx = 12'd0;
                next_state = after_addr;
              end
            end
            S_WDATA: begin
              next_idx = idx + 12'd1;
              next_state = S_WWAIT;
              if (idx == cmd.len - 12'd1) begin
                next_idx = 12'd0;
                next_state = after_w;
              end
            end
            S_CMD2: next_state = after_c2;
            S_STCMD: begin
              next_st_rd = 1'b1;
              next_state = S_RDATA;
            end
            S_RDATA: begin
              next_idx = idx + 12'd1;
              if (idx == rd_last - 12'd1) begin
                next_idx = 12'd0;
                next_state = S_DONE;
              end
            end
            default: next_state = S_IDLE;
          endcase
        end
      end
    endcase
  end

  // Pin values, registered so every pin moves on the same edge
  assign pins_next.command_latch_strobe = (state == S_CMD1) || (state == S_CMD2) || (state == S_STCMD);
  assign pins_next.address_latch_strobe = (state == S_ADDR);
  assign pins_next.chip_select_n = (state == S_IDLE) || (state == S_DONE);
  assign pins_next.write_strobe_n = !(wr_cyc && !ph);
  assign pins_next.output_strobe_n = !((state == S_RDATA) && !ph);
  assign pins_next.write_protect_n = !protect_i;
  assign pins_next.io_bus = io_next;
  assign pins_next.io_bus_oe = wr_cyc;

  // Phase divider
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) div <= 8'h00;
    else div <= (!byte_cyc || tick) ? 8'h00 : div + 8'h01;
  end

  // State and data registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= S_IDLE;
      ph <= 1'b0;
      idx <= 12'h000;
      cmd <= '0;
      wbyte <= 8'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      fail <= 1'b0;
      status <= 8'h00;
      wcnt <= 8'h00;
      st_rd <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      ph <= next_ph;
      idx <= next_idx;
      cmd <= next_cmd;
      wbyte <= next_wbyte;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      fail <= next_fail;
      status <= next_status;
      wcnt <= next_wcnt;
      st_rd <= next_st_rd;
      done <= (state == S_DONE);
    end
  end

  // Pins: idle with select high, strobes high, bus released
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) pins_o <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0};
    else pins_o <= pins_next;
  end

  // User outputs
  assign rd_data_o = rd_data;
  assign rd_valid_o = rd_valid;
  assign done_o = done;
  assign fail_o = fail;
  assign status_o = status;
  assign busy_o = (state != S_IDLE);

endmodule : nfc_host

// *** rtl/nfc_pkg.sv ***
package nfc_pkg;

  // Bus timing at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int PHASE_NS = 150;
  localparam int PH_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int TWB_NS = 100;
  localparam int WB_CYC = (TWB_NS * CLK_MHZ + 999) / 1000;

  // Page geometry
  localparam logic [11:0] PAGE_BYTES = 12'd2112;
  localparam logic [11:0] MAIN_BYTES = 12'd2048;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS = 1024;
  localparam int PAGE_LSB = 0;
  localparam int BLOCK_LSB = 6;

  // Data buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 8;

  // Status byte fields
  localparam int ST_READY_BIT = 7;
  localparam int ST_FAIL_BIT = 1;

  // Command codes
  localparam logic [7:0] C_READ = 8'h00;
  localparam logic [7:0] C_READ_GO = 8'h30;
  localparam logic [7:0] C_COPY_GO = 8'h35;
  localparam logic [7:0] C_COL_OUT = 8'h05;
  localparam logic [7:0] C_COL_OUT_GO = 8'hE0;
  localparam logic [7:0] C_PROG = 8'h80;
  localparam logic [7:0] C_PROG_GO = 8'h10;
  localparam logic [7:0] C_COL_IN = 8'h85;
  localparam logic [7:0] C_ERASE = 8'h60;
  localparam logic [7:0] C_ERASE_GO = 8'hD0;
  localparam logic [7:0] C_ID = 8'h90;
  localparam logic [7:0] C_STATUS = 8'h70;
  localparam logic [7:0] C_ECC_ST = 8'h7A;
  localparam logic [7:0] C_RESET = 8'hFF;
  localparam logic [7:0] C_NONE = 8'h00;

  typedef enum logic [3:0] {
    OP_READ, OP_COPY_READ, OP_COL_OUT, OP_PROG, OP_COPY_PROG,
    OP_ERASE, OP_STATUS, OP_ECC_STATUS, OP_ID, OP_RESET
  } nfc_op_type;

  // User request
  typedef struct packed {
    nfc_op_type op;
    logic [15:0] row;
    logic [11:0] col;
    logic [11:0] len;
  } nfc_cmd_type;

  // Flash pins driven by the host
  typedef struct packed {
    logic command_latch_strobe;
    logic address_latch_strobe;
    logic chip_select_n;
    logic write_strobe_n;
    logic output_strobe_n;
    logic write_protect_n;
    logic [7:0] io_bus;
    logic io_bus_oe;
  } nfc_pins_type;

  // Shape of one operation
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic has_c2;
    logic [2:0] abase;
    logic [2:0] an;
    logic wr;
    logic rd;
    logic busy;
    logic stat;
    logic prot;
    logic busy_ok;
  } nfc_desc_type;

  function automatic nfc_desc_type nfc_desc(input nfc_op_type op);
    nfc_desc_type d;
    d = '{C_NONE, C_NONE, 1'b0, 3'd0, 3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    case (op)
      OP_READ: d = '{C_READ, C_READ_GO, 1'b1, 3'd0, 3'd4, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      OP_COPY_READ: d = '{C_READ, C_COPY_GO, 1'b1, 3'd0, 3'd4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      OP_COL_OUT: d = '{C_COL_OUT, C_COL_OUT_GO, 1'b1, 3'd0, 3'd2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_PROG: d = '{C_PROG, C_PROG_GO, 1'b1, 3'd0, 3'd4, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      OP_COPY_PROG: d = '{C_COL_IN, C_PROG_GO, 1'b1, 3'd0, 3'd4, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      OP_ERASE: d = '{C_ERASE, C_ERASE_GO, 1'b1, 3'd2, 3'd2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      OP_STATUS: d = '{C_STATUS, C_NONE, 1'b0, 3'd0, 3'd0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      OP_ECC_STATUS: d = '{C_ECC_ST, C_NONE, 1'b0, 3'd0, 3'd0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_ID: d = '{C_ID, C_NONE, 1'b0, 3'd4, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_RESET: d = '{C_RESET, C_NONE, 1'b0, 3'd0, 3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      default: d = '{C_NONE, C_NONE, 1'b0, 3'd0, 3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    return d;
  endfunction : nfc_desc

endpackage : nfc_pkg

// *** rtl/nfc_fifo.sv ***
module nfc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Fill side
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty straight from the fill count
  assign in_ready_o = (count != (AW + 1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) mem[wptr] <= in_data_i;
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      if (pop) rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule : nfc_fifo

// *** rtl/nfc_sync.sv ***
module nfc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // Two flops per bit; the first feeds only the second
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        meta[b] <= 1'b0;
        sync_o[b] <= 1'b0;
      end else begin
        meta[b] <= async_i[b];
        sync_o[b] <= meta[b];
      end
    end
  end

endmodule : nfc_sync

// *** test/nfc_host_asserts.sv ***
module nfc_host_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Watched ports
  input wire nfc_pkg::nfc_cmd_type cmd_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic protect_i,
  input wire logic rd_valid_o,
  input wire logic done_o,
  input wire logic fail_o,
  input wire nfc_pkg::nfc_pins_type pins_o,
  input wire logic ready_busy_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic take;
  // Accepted request
  assign take = cmd_valid_i && cmd_ready_o;
  strobe_excl_a: assert property (!(pins_o.command_latch_strobe && pins_o.address_latch_strobe))
    else $error("both latch strobes high");
  we_phase_a: assert property ($fell(pins_o.write_strobe_n) |->
    (!pins_o.write_strobe_n && pins_o.io_bus_oe)[*6] ##1 pins_o.write_strobe_n) else $error("write strobe phase");
  we_hold_a: assert property (!pins_o.write_strobe_n && !$past(pins_o.write_strobe_n) |->
    $stable(pins_o.address_latch_strobe) && $stable(pins_o.command_latch_strobe) && $stable(pins_o.io_bus))
    else $error("latch inputs moved under write strobe");
  oe_release_a: assert property (!pins_o.output_strobe_n |-> !pins_o.io_bus_oe && pins_o.write_strobe_n)
    else $error("bus driven during output strobe");
  busy_strobe_a: assert property ((!ready_busy_n_i)[*4] ##0 !pins_o.command_latch_strobe |->
    pins_o.write_strobe_n && pins_o.output_strobe_n) else $error("strobe while device busy");
  busy_cmd_a: assert property ((!ready_busy_n_i)[*4] ##0 ($rose(pins_o.write_strobe_n) &&
    $past(pins_o.command_latch_strobe)) |-> $past(pins_o.io_bus) inside {C_STATUS, C_RESET})
    else $error("command not allowed while busy");
  prot_pin_a: assert property (protect_i[*2] |-> !pins_o.write_protect_n) else $error("protect pin high");
  prot_refuse_a: assert property (take && protect_i && cmd_i.op inside {OP_PROG, OP_COPY_PROG, OP_ERASE}
    |-> ##[1:4] (done_o && fail_o && pins_o.chip_select_n)) else $error("protected op not refused");
  bad_col_a: assert property (take && cmd_i.op == OP_READ && cmd_i.col >= PAGE_BYTES |->
    ##[1:4] (done_o && fail_o && pins_o.chip_select_n)) else $error("bad column not refused");
  rd_low_a: assert property (rd_valid_o |-> !$past(pins_o.output_strobe_n)) else $error("read byte without strobe");
  done_idle_a: assert property (done_o |-> ##[0:2] pins_o.chip_select_n) else $error("select held after done");
endmodule : nfc_host_asserts

bind nfc_host nfc_host_asserts u_chk (.clk_i, .nrst_i, .cmd_i, .cmd_valid_i, .cmd_ready_o, .protect_i,
  .rd_valid_o, .done_o, .fail_o, .pins_o, .ready_busy_n_i);

// *** test/nfc_flash_model.sv ***
module nfc_flash_model #(
  parameter int READ_NS = 2000,
  parameter int PROG_NS = 5000,
  parameter logic [7:0] ID_BYTE = 8'h5A, // Arbitrary value
  parameter logic [7:0] ECC_BYTE = 8'h00
) (
  // Host pins
  input wire nfc_pkg::nfc_pins_type pins_i,
  input wire logic fail_prog_i,
  // Device pins
  output logic [7:0] io_o,
  output logic ready_busy_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] pbuf [0:2111];
  logic [7:0] ab [0:3];
  logic [7:0] cmd = C_READ;
  logic [7:0] dout = 8'h00;
  logic fail = 1'b0;
  logic standby;
  int acnt = 0;
  int col = 0;
  int row = 0;
  initial ready_busy_n_o = 1'b1;
  // Low power only when deselected and ready
  assign standby = pins_i.chip_select_n && ready_busy_n_o;
  task automatic go(input int t);
    ready_busy_n_o = 1'b0;
    fork
      #(t) ready_busy_n_o = 1'b1;
    join_none
  endtask : go
  task automatic on_cmd(input logic [7:0] c);
    int q[$];
    cmd = c;
    acnt = 0;
    case (c)
      C_READ_GO, C_COPY_GO: begin
        for (int i = 0; i < 2112; i++) pbuf[i] = mem.exists(row * 4096 + i) ? mem[row * 4096 + i] : 8'hFF;
        go(READ_NS);
      end
      C_PROG: foreach (pbuf[i]) pbuf[i] = 8'hFF;
      C_PROG_GO: if (pins_i.write_protect_n) begin
        foreach (pbuf[i]) mem[row * 4096 + i] = pbuf[i];
        fail = fail_prog_i;
        go(PROG_NS);
      end
      C_ERASE_GO: if (pins_i.write_protect_n) begin
        foreach (mem[k]) if ((k >> 18) == (row >> 6)) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
        go(PROG_NS);
      end
      C_RESET: go(500);
      default: ;
    endcase
  endtask : on_cmd
  // Command, address and data latch on write strobe rise
  always @(posedge pins_i.write_strobe_n) begin
    if (!pins_i.chip_select_n && pins_i.output_strobe_n) begin
      if (pins_i.command_latch_strobe) begin
        if (ready_busy_n_o || pins_i.io_bus inside {C_STATUS, C_RESET}) on_cmd(pins_i.io_bus);
      end else if (pins_i.address_latch_strobe && ready_busy_n_o) begin
        ab[(acnt + ((cmd == C_ERASE) ? 2 : 0)) % 4] = pins_i.io_bus;
        acnt++;
        col = {ab[1][3:0], ab[0]};
        row = {ab[3], ab[2]};
      end else if (pins_i.write_protect_n && ready_busy_n_o) begin
        pbuf[col] = pins_i.io_bus;
        col++;
      end
    end
  end
  // Serial output on output strobe fall; modes hold until the next command
  always @(negedge pins_i.output_strobe_n) begin
    if (!pins_i.chip_select_n) begin
      case (cmd)
        C_STATUS: dout = {ready_busy_n_o, 5'h00, fail, 1'b0};
        C_ID: dout = ID_BYTE;
        C_ECC_ST: dout = ECC_BYTE;
        default: begin
          dout = pbuf[col];
          col++;
        end
      endcase
    end
  end
  // Released bus shows the inverse so a stale value never passes
  assign io_o = (!pins_i.chip_select_n && !pins_i.output_strobe_n) ? dout : ~dout;
endmodule : nfc_flash_model

// *** test/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;
  localparam logic [7:0] ID_B = 8'hC3; // Arbitrary value
  logic clk_i, nrst_i, cmd_valid_i, protect_i, wr_valid_i, fail_prog;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, fail_o, busy_o, rb_n;
  logic [7:0] wr_data_i, rd_data_o, status_o, io_bus_i, flash_io;
  nfc_cmd_type cmd_i;
  nfc_pins_type pins_o;
  int bad_count, checks, cyc;
  logic [7:0] rq [$];
  // Shared data bus, host wins while it drives
  assign io_bus_i = pins_o.io_bus_oe ? pins_o.io_bus : flash_io;
  nfc_host dut (.clk_i, .nrst_i, .cmd_i, .cmd_valid_i, .cmd_ready_o, .protect_i, .wr_data_i, .wr_valid_i,
    .wr_ready_o, .rd_data_o, .rd_valid_o, .done_o, .fail_o, .status_o, .busy_o, .pins_o, .io_bus_i,
    .ready_busy_n_i(rb_n));
  nfc_flash_model #(.ID_BYTE(ID_B)) m (.pins_i(pins_o), .fail_prog_i(fail_prog), .io_o(flash_io),
    .ready_busy_n_o(rb_n));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Read bytes as they arrive; no back-pressure exists
  always @(posedge clk_i) if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  function automatic logic [7:0] pat(input int i);
    return 8'h30 + 8'(i);
  endfunction : pat
  // One request, held until taken, then wait for completion
  task automatic run(input nfc_op_type op, input logic [15:0] row, input logic [11:0] col, input logic [11:0] n);
    rq.delete();
    @(posedge clk_i);
    cmd_i <= '{op, row, col, n};
    cmd_valid_i <= 1'b1;
    forever begin
      @(negedge clk_i);
      if (cmd_ready_o === 1'b1) break;
    end
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    forever begin
      @(negedge clk_i);
      if (done_o === 1'b1) break;
    end
    @(negedge clk_i);
  endtask : run
  task automatic push(input logic [7:0] b);
    @(posedge clk_i);
    wr_data_i <= b;
    wr_valid_i <= 1'b1;
    forever begin
      @(negedge clk_i);
      if (wr_ready_o === 1'b1) break;
    end
    @(posedge clk_i);
    wr_valid_i <= 1'b0;
  endtask : push
  task automatic t_program;
    for (int i = 0; i < 8; i++) push(pat(i));
    @(negedge clk_i);
    check(wr_ready_o, 0);
    fork
      run(OP_PROG, 16'h0041, 12'd5, 12'd10);
      begin
        push(pat(8));
        push(pat(9));
      end
    join
    check(fail_o, 0);
    check(status_o, 8'h80);
    check(m.mem[32'h4100E], pat(9));
  endtask : t_program
  task automatic t_read;
    run(OP_READ, 16'h0041, 12'd5, 12'd10);
    check(rq.size(), 10);
    foreach (rq[i]) check(rq[i], pat(i));
    run(OP_COL_OUT, 16'h0041, 12'd9, 12'd3);
    foreach (rq[i]) check(rq[i], pat(4 + i));
    run(OP_READ, 16'h0041, 12'd2111, 12'd1);
    check(rq[0], 8'hFF);
    run(OP_READ, 16'h0041, 12'd2112, 12'd1);
    check(fail_o, 1);
  endtask : t_read
  task automatic t_copy;
    run(OP_COPY_READ, 16'h0041, 12'd0, 12'd0);
    push(8'hA5);
    run(OP_COPY_PROG, 16'h0082, 12'd7, 12'd1);
    run(OP_READ, 16'h0082, 12'd5, 12'd3);
    check({rq[0], rq[1], rq[2]}, {pat(0), pat(1), 8'hA5});
  endtask : t_copy
  task automatic t_erase;
    run(OP_ERASE, 16'h0040, 12'd0, 12'd0);
    check(fail_o, 0);
    run(OP_READ, 16'h0041, 12'd5, 12'd2);
    check({rq[0], rq[1]}, 16'hFFFF);
    run(OP_READ, 16'h0082, 12'd7, 12'd1);
    check(rq[0], 8'hA5);
  endtask : t_erase
  task automatic t_protect;
    @(posedge clk_i);
    protect_i <= 1'b1;
    run(OP_ERASE, 16'h0082, 12'd0, 12'd0);
    check(fail_o, 1);
    run(OP_PROG, 16'h0082, 12'd7, 12'd0);
    check(fail_o, 1);
    @(posedge clk_i);
    protect_i <= 1'b0;
    run(OP_READ, 16'h0082, 12'd7, 12'd1);
    check(rq[0], 8'hA5);
  endtask : t_protect
  task automatic t_status;
    fail_prog <= 1'b1;
    run(OP_PROG, 16'h00C0, 12'd0, 12'd0);
    check({fail_o, status_o}, 9'h182);
    fail_prog <= 1'b0;
    run(OP_STATUS, 16'h0000, 12'd0, 12'd2);
    check({rq[0], rq[1]}, 16'h8282);
    run(OP_ID, 16'h0000, 12'd0, 12'd1);
    check(rq[0], ID_B);
    run(OP_ECC_STATUS, 16'h0000, 12'd0, 12'd1);
    check(rq[0], 8'h00);
    run(OP_RESET, 16'h0000, 12'd0, 12'd0);
    check(fail_o, 0);
    check(busy_o, 0);
    check(m.standby, 1);
  endtask : t_status
  initial begin
    nrst_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '{OP_READ, 16'h0000, 12'h000, 12'h000};
    protect_i = 1'b0;
    wr_valid_i = 1'b0;
    wr_data_i = 8'h00;
    fail_prog = 1'b0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_program();
    t_read();
    t_copy();
    t_erase();
    t_protect();
    t_status();
    conclude();
  end
endmodule : tb
